// [hdl/fis_sequencer.sv]
`timescale 1ns/1ps
module fis_sequencer
  import fis_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // slow-control host port
  input wire fis_host_req_s host_i,
  output logic [23:0] host_rdata_o,
  output logic busy_o,
  // front-end bus
  output fis_bus_txn_s txn_o,
  input wire logic txn_ack_i,
  input wire logic [19:0] txn_rdata_i,
  // chip-side trigger and status inputs
  input wire logic first_level_trigger_i,
  input wire logic second_level_trigger_i,
  input wire logic [7:0] last_event_length_i,
  input wire logic [7:0] hardwired_chip_id_i,
  input wire logic [6:0] chip_error_bits_i,
  // chip register and command outputs
  output logic [19:0] trigger_window_o,
  output logic [19:0] datapath_config_one_o,
  output logic [19:0] datapath_config_two_o,
  output logic [19:0] baseline_memory_pointer_o,
  output logic channel_readout_o
);

  typedef enum {S_IDLE, S_FETCH, S_DATA, S_ISSUE, S_WAIT} fis_state_e;

  fis_state_e state;
  logic [23:0] instruction_store [INSTRUCTION_STORE_DEPTH];
  logic [19:0] rmem [INSTRUCTION_STORE_DEPTH];
  logic [7:0] pc;
  logic [7:0] line;
  logic [23:0] cur;
  logic [2:0] tl_sync;
  logic [2:0] tr2_sync;
  logic [2:0] wp;
  logic [2:0] rp;
  logic [6:0] err_flags;
  logic [15:0] trigger_count;
  logic [19:0] err_word;
  logic bc_wr;
  logic [7:0] bc_reg;
  logic first_trig;
  logic accept;
  logic release_buf;
  logic [3:0] used;
  logic [3:0] buffer_count_select;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] base,
                               input logic [15:0] mask);
    hit = (a & mask) == base;
  endfunction : hit

  function automatic logic is_cmd(input logic [7:0] want);
    is_cmd = bc_wr && bc_reg == want;
  endfunction : is_cmd

  assign bc_wr = host_i.wr && hit(host_i.addr, BCAST_BASE, BCAST_MASK);
  assign bc_reg = host_i.addr[7:0];

  // trigger pins synchronised before use
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tl_sync <= 3'h0;
      tr2_sync <= 3'h0;
    end else begin
      tl_sync <= {tl_sync[1:0], first_level_trigger_i};
      tr2_sync <= {tr2_sync[1:0], second_level_trigger_i};
    end
  end

  assign first_trig = (tl_sync[1] && !tl_sync[2]) || is_cmd(CMD_SW_TRIG);
  assign accept = (tr2_sync[1] && !tr2_sync[2]) || is_cmd(CMD_WP_ADV);
  assign release_buf = is_cmd(CMD_RP_ADV) && used != 4'h0;
  assign buffer_count_select = datapath_config_two_o[4] ? BUF_EIGHT : BUF_FOUR;

  // instruction store write port
  always_ff @(posedge mclk_i) begin
    if (host_i.wr && hit(host_i.addr, INSTRUCTION_STORE_BASE, INSTRUCTION_STORE_MASK)) begin
      instruction_store[host_i.addr[7:0]] <= host_i.wdata;
    end
  end

  // configuration registers written by broadcast
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      trigger_window_o <= TRIG_WINDOW_RESET;
      datapath_config_one_o <= DP_ONE_RESET;
      datapath_config_two_o <= DP_TWO_RESET;
      baseline_memory_pointer_o <= 20'h00000;
    end else if (bc_wr) begin
      unique case (bc_reg)
        REG_TRIG_WINDOW: trigger_window_o <= host_i.wdata[19:0];
        REG_DP_ONE: datapath_config_one_o <= host_i.wdata[19:0];
        REG_DP_TWO: datapath_config_two_o <= {13'h0000, host_i.wdata[6:0]};
        REG_BASE_PTR: baseline_memory_pointer_o <= {10'h000,
                                                     host_i.wdata[9:0]};
        default: ;
      endcase
    end
  end

  // trigger counter; a clear in the same cycle as a trigger keeps it
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      trigger_count <= 16'h0000;
    end else if (is_cmd(CMD_TC_CLR)) begin
      trigger_count <= first_trig ? 16'h0001 : 16'h0000;
    end else if (first_trig) begin
      trigger_count <= trigger_count + 16'h0001;
    end
  end

  // event buffer pointers
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wp <= 3'h0;
      rp <= 3'h0;
      used <= 4'h0;
    end else begin
      if (accept && used != buffer_count_select) begin
        wp <= wp + 3'h1;
      end
      if (release_buf) begin
        rp <= rp + 3'h1;
      end
      used <= used + {3'h0, accept && used != buffer_count_select} - {3'h0, release_buf};
    end
  end

  // sticky error flags: set wins over clear
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      err_flags <= 7'h00;
    end else if (is_cmd(CMD_ERR_CLR)) begin
      err_flags <= chip_error_bits_i;
    end else begin
      err_flags <= err_flags | chip_error_bits_i;
    end
  end

  // parity source shows in bit 12 and again as lowest sticky bit
  assign err_word = {err_flags, err_flags[0], used == 4'h0, used == buffer_count_select,
                     buffer_count_select - used, wp, rp};

  // readout strobe one cycle after command
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      channel_readout_o <= 1'b0;
    end else begin
      channel_readout_o <= is_cmd(CMD_CH_RDO);
    end
  end

  // sequencer; execute ignored while running
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state <= S_IDLE;
      pc <= 8'h00;
      line <= 8'h00;
      cur <= 24'h000000;
      txn_o <= '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (host_i.wr && hit(host_i.addr, EXEC_BASE, EXEC_MASK)) begin
            pc <= host_i.addr[7:0];
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          cur <= instruction_store[pc];
          line <= pc;
          pc <= pc + 8'h01;
          if (instruction_store[pc] == END_WORD) begin
            state <= S_IDLE;
          end else if (instruction_store[pc][23:20] == OP_READ) begin
            state <= S_ISSUE;
          end else if (instruction_store[pc][23:20] == OP_WADDR) begin
            state <= S_DATA;
          end else begin
            state <= S_FETCH;
          end
        end
        S_DATA: begin
          pc <= pc + 8'h01;
          if (instruction_store[pc][23:20] == OP_WDATA) begin
            txn_o.data <= instruction_store[pc][19:0];
            state <= S_ISSUE;
          end else begin
            state <= S_FETCH;
          end
        end
        S_ISSUE: begin
          txn_o.valid <= 1'b1;
          txn_o.write <= cur[23:20] == OP_WADDR;
          txn_o.branch_b <= cur[19:16] == BR_B;
          txn_o.card <= cur[15:12];
          txn_o.reg_addr <= cur[11:0];
          if (cur[23:20] == OP_READ) begin
            txn_o.data <= 20'h00000;
          end
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (txn_ack_i) begin
            txn_o.valid <= 1'b0;
            state <= S_FETCH;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // result memory, one entry per line
  always_ff @(posedge mclk_i) begin
    if (state == S_WAIT && txn_ack_i && !txn_o.write) begin
      rmem[line] <= txn_rdata_i;
    end
  end

  // host read data
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      host_rdata_o <= 24'h000000;
    end else if (host_i.rd) begin
      if (hit(host_i.addr, INSTRUCTION_STORE_BASE, INSTRUCTION_STORE_MASK)) begin
        host_rdata_o <= instruction_store[host_i.addr[7:0]];
      end else if (hit(host_i.addr, RMEM_BASE, RMEM_MASK)) begin
        host_rdata_o <= {4'h0, rmem[host_i.addr[7:0]]};
      end else if (hit(host_i.addr, BCAST_BASE, BCAST_MASK)) begin
        unique case (bc_reg)
          REG_TRIG_WINDOW: host_rdata_o <= {4'h0, trigger_window_o};
          REG_DP_ONE: host_rdata_o <= {4'h0, datapath_config_one_o};
          REG_DP_TWO: host_rdata_o <= {4'h0, datapath_config_two_o};
          REG_BASE_PTR: host_rdata_o <= {4'h0, baseline_memory_pointer_o};
          REG_ERR: host_rdata_o <= {4'h0, err_word};
          REG_EVLEN: host_rdata_o <= {8'h00, hardwired_chip_id_i,
                                      last_event_length_i};
          REG_TRGCNT: host_rdata_o <= {8'h00, trigger_count};
          default: host_rdata_o <= 24'h000000;
        endcase
      end else begin
        host_rdata_o <= 24'h000000;
      end
    end
  end

  assign busy_o = state != S_IDLE;

  property p_exec_start;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (state == S_IDLE && host_i.wr && host_i.addr[15:8] == 8'h00)
      |=> (state == S_FETCH && pc == $past(host_i.addr[7:0]));
  endproperty
  a_exec_start: assert property (p_exec_start)
    else $error("execute did not start at offset");

  property p_end_stops;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (state == S_FETCH && instruction_store[pc] == END_WORD) |=> state == S_IDLE;
  endproperty
  a_end_stops: assert property (p_end_stops)
    else $error("end word did not stop sequencer");

  property p_read_one_word;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (state == S_FETCH && instruction_store[pc][23:20] == OP_READ)
      |=> ##1 (txn_o.valid && !txn_o.write);
  endproperty
  a_read_one_word: assert property (p_read_one_word)
    else $error("read word did not issue a read");

  property p_write_pair;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (state == S_DATA && instruction_store[pc][23:20] == OP_WDATA)
      |=> ##1 (txn_o.valid && txn_o.write
               && txn_o.data == $past(instruction_store[pc][19:0], 2));
  endproperty
  a_write_pair: assert property (p_write_pair)
    else $error("write pair data mismatch");

  property p_branch;
    @(posedge mclk_i) disable iff (!reset_n_i)
    state == S_ISSUE |=> txn_o.branch_b == ($past(cur[19:16]) == BR_B)
                        && txn_o.card == $past(cur[15:12]);
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch or card field wrong");

  property p_trig_count;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (first_trig && !is_cmd(CMD_TC_CLR))
      |=> trigger_count == $past(trigger_count) + 16'h0001;
  endproperty
  a_trig_count: assert property (p_trig_count)
    else $error("trigger counter did not advance");

  property p_tc_clear;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (is_cmd(CMD_TC_CLR) && !first_trig) |=> trigger_count == 16'h0000;
  endproperty
  a_tc_clear: assert property (p_tc_clear)
    else $error("trigger counter not cleared");

  property p_release;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (release_buf && !accept) |=> used == $past(used) - 4'h1;
  endproperty
  a_release: assert property (p_release)
    else $error("buffer not released");

  property p_readout;
    @(posedge mclk_i) disable iff (!reset_n_i)
    1'b1 |=> channel_readout_o == $past(is_cmd(CMD_CH_RDO));
  endproperty
  a_readout: assert property (p_readout)
    else $error("readout strobe does not follow command");

  property p_idle_holds;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (state == S_IDLE && !(host_i.wr && host_i.addr[15:8] == 8'h00))
      |=> (state == S_IDLE && !txn_o.valid);
  endproperty
  a_idle_holds: assert property (p_idle_holds)
    else $error("sequencer left idle without execute");

  property p_window_write;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (bc_wr && bc_reg == REG_TRIG_WINDOW)
      |=> trigger_window_o == $past(host_i.wdata[19:0]);
  endproperty
  a_window_write: assert property (p_window_write)
    else $error("trigger window not written");

  property p_dp_one_write;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (bc_wr && bc_reg == REG_DP_ONE)
      |=> datapath_config_one_o == $past(host_i.wdata[19:0]);
  endproperty
  a_dp_one_write: assert property (p_dp_one_write)
    else $error("datapath one not written");

  property p_err_sticky;
    @(posedge mclk_i) disable iff (!reset_n_i)
    !is_cmd(CMD_ERR_CLR)
      |=> (err_flags & $past(err_flags)) == $past(err_flags);
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag dropped without clear");

  property p_result_store;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (state == S_WAIT && txn_ack_i && !txn_o.write)
      |=> rmem[line] == $past(txn_rdata_i);
  endproperty
  a_result_store: assert property (p_result_store)
    else $error("read result not stored");

endmodule : fis_sequencer

// [hdl/fis_pkg.sv]
package fis_pkg;
  // host-side command map
  localparam logic [15:0] EXEC_BASE = 16'h0000;
  localparam logic [15:0] EXEC_MASK = 16'hFF00;
  localparam logic [15:0] INSTRUCTION_STORE_BASE = 16'h7000;
  localparam logic [15:0] INSTRUCTION_STORE_MASK = 16'hFF00;
  localparam logic [15:0] RMEM_BASE = 16'h6000;
  localparam logic [15:0] RMEM_MASK = 16'hFF00;
  localparam logic [15:0] BCAST_BASE = 16'h4000;
  localparam logic [15:0] BCAST_MASK = 16'hFF00;
  localparam int INSTRUCTION_STORE_DEPTH = 256;
  // instruction word fields
  localparam logic [3:0] OP_READ = 4'h5;
  localparam logic [3:0] OP_WADDR = 4'h6;
  localparam logic [3:0] OP_WDATA = 4'h7;
  localparam logic [23:0] END_WORD = 24'h390000;
  localparam logic [3:0] BR_A = 4'h2;
  localparam logic [3:0] BR_B = 4'h3;
  // chip register offsets
  localparam logic [7:0] REG_TRIG_WINDOW = 8'h0A;
  localparam logic [7:0] REG_DP_ONE = 8'h0B;
  localparam logic [7:0] REG_DP_TWO = 8'h0C;
  localparam logic [7:0] REG_BASE_PTR = 8'h0D;
  localparam logic [7:0] REG_ERR = 8'h10;
  localparam logic [7:0] REG_EVLEN = 8'h11;
  localparam logic [7:0] REG_TRGCNT = 8'h12;
  localparam logic [7:0] CMD_WP_ADV = 8'h18;
  localparam logic [7:0] CMD_RP_ADV = 8'h19;
  localparam logic [7:0] CMD_CH_RDO = 8'h1A;
  localparam logic [7:0] CMD_SW_TRIG = 8'h1B;
  localparam logic [7:0] CMD_TC_CLR = 8'h1C;
  localparam logic [7:0] CMD_ERR_CLR = 8'h1D;
  localparam logic [19:0] DP_ONE_RESET = 20'h00000;
  localparam logic [19:0] TRIG_WINDOW_RESET = 20'h00000;
  localparam logic [19:0] DP_TWO_RESET = 20'h00000;
  localparam logic [3:0] BUF_FOUR = 4'h4;
  localparam logic [3:0] BUF_EIGHT = 4'h8;
  localparam logic [7:0] CHIP_ID_DEFAULT = 8'h00; // arbitrary value

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [23:0] wdata;
  } fis_host_req_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic branch_b;
    logic [3:0] card;
    logic [11:0] reg_addr;
    logic [19:0] data;
  } fis_bus_txn_s;
endpackage : fis_pkg

// [verif/fis_fe_model.sv]
`timescale 1ns/1ps
// front-end card stand-in: acks after a chosen wait, logs the last access
module fis_fe_model
  import fis_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // bus from the sequencer
  input wire fis_bus_txn_s txn_i,
  input wire logic [3:0] wait_i,
  output logic ack_o,
  output logic [19:0] rdata_o,
  // observation
  output fis_bus_txn_s seen_o,
  output int n_txn_o
);
  logic [3:0] cnt;
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      rdata_o <= 20'h00000;
      seen_o <= '0;
      n_txn_o <= 0;
      cnt <= 4'h0;
    end else if (txn_i.valid && !ack_o && cnt >= wait_i) begin
      ack_o <= 1'b1;
      rdata_o <= {txn_i.card, 4'hA, txn_i.reg_addr};
      seen_o <= txn_i;
      n_txn_o <= n_txn_o + 1;
      cnt <= 4'h0;
    end else begin
      ack_o <= 1'b0;
      // released data lines must not hold a stale value
      rdata_o <= ~rdata_o;
      cnt <= txn_i.valid && !ack_o ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : fis_fe_model

// [verif/front_end_instruction_sequencer_test.sv]
`timescale 1ns/1ps
module front_end_instruction_sequencer_test;
  import fis_pkg::*;
  logic mclk_i, reset_n_i, busy, ack, rdo, trig1, trig2;
  fis_host_req_s host;
  fis_bus_txn_s txn, seen;
  logic [23:0] hrd, d;
  logic [19:0] fe_rd, tw, dp1, dp2, bmp;
  logic [7:0] ev_len, chip_id;
  logic [6:0] err_bits;
  logic [3:0] wait_cyc;
  int n_txn, n0, n_rdo, miscompares, n_checks;

  fis_sequencer dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .host_i(host),
    .host_rdata_o(hrd), .busy_o(busy), .txn_o(txn), .txn_ack_i(ack),
    .txn_rdata_i(fe_rd), .first_level_trigger_i(trig1),
    .second_level_trigger_i(trig2), .last_event_length_i(ev_len),
    .hardwired_chip_id_i(chip_id), .chip_error_bits_i(err_bits),
    .trigger_window_o(tw), .datapath_config_one_o(dp1),
    .datapath_config_two_o(dp2), .baseline_memory_pointer_o(bmp),
    .channel_readout_o(rdo));
  fis_fe_model fe (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .txn_i(txn),
    .wait_i(wait_cyc),
    .ack_o(ack), .rdata_o(fe_rd), .seen_o(seen), .n_txn_o(n_txn));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) if (rdo === 1'b1) n_rdo++;

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [23:0] v);
    @(posedge mclk_i) host <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge mclk_i) host <= '0;
    // let the register update settle before callers look at it
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge mclk_i) host <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 24'h0};
    @(posedge mclk_i) host <= '0;
    @(posedge mclk_i) #1 d = hrd;
  endtask : rd
  task automatic run(input logic [7:0] off);
    n0 = n_txn;
    wr({8'h00, off}, 24'h000000);
    repeat (3) @(posedge mclk_i);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge mclk_i);
    chk("busy", 24'h0, {23'h0, busy});
  endtask : run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic t_reset();
    chk("dp1 reset", 24'h0, {4'h0, dp1});
    chk("busy reset", 24'h0, {23'h0, busy});
    rd(16'h5000);
    chk("unmapped", 24'h0, d);
    rd(16'h4018);
    chk("write-only", 24'h0, d);
  endtask : t_reset
  task automatic t_bcast();
    wr(16'h400A, 24'h0C8A9);
    chk("window", 24'h0C8A9, {4'h0, tw});
    rd(16'h400A);
    chk("window rd", 24'h0C8A9, d);
    wr(16'h400C, 24'hFFFFF);
    chk("dp2", 24'h7F, {4'h0, dp2});
    wr(16'h400B, 24'h80123);
    chk("dp1", 24'h80123, {4'h0, dp1});
    wr(16'h400D, 24'hFFFFF);
    chk("base ptr", 24'h3FF, {4'h0, bmp});
  endtask : t_bcast
  task automatic t_read_seq();
    wait_cyc <= 4'h3;
    wr(16'h7000, 24'h533041);
    wr(16'h7001, END_WORD);
    chk("idle", 0, n_txn - n0);
    rd(16'h7000);
    chk("instruction_store", 24'h533041, d);
    run(8'h00);
    chk("count", 1, n_txn - n0);
    chk("rd txn", {1'b0, 1'b1, 4'h3, 12'h041}, {seen.write,
        seen.branch_b, seen.card, seen.reg_addr});
    rd(16'h6000);
    chk("result", 24'h3A041, d);
  endtask : t_read_seq
  task automatic t_write_seq();
    wait_cyc <= 4'h0;
    wr(16'h7010, 24'h623040);
    wr(16'h7011, 24'h70029A);
    wr(16'h7012, END_WORD);
    run(8'h10);
    chk("count", 1, n_txn - n0);
    chk("wr txn", {1'b1, 1'b0, 4'h3, 12'h040}, {seen.write,
        seen.branch_b, seen.card, seen.reg_addr});
    chk("wr data", 24'h0029A, {4'h0, seen.data});
  endtask : t_write_seq
  task automatic t_trig();
    wr(16'h401C, 24'h0);
    @(posedge mclk_i) trig1 <= 1'b1;
    repeat (3) @(posedge mclk_i);
    trig1 <= 1'b0;
    repeat (4) @(posedge mclk_i);
    wr(16'h401B, 24'h0);
    rd(16'h4012);
    chk("trig count", 24'h2, d);
    wr(16'h401C, 24'h0);
    rd(16'h4012);
    chk("count clear", 24'h0, d);
  endtask : t_trig
  task automatic t_status();
    ev_len <= 8'h2C;
    chip_id <= 8'h5E;
    err_bits <= 7'h02;
    repeat (4) @(posedge mclk_i);
    err_bits <= 7'h00;
    rd(16'h4011);
    chk("evlen id", 24'h5E2C, d);
    rd(16'h4010);
    chk("err bit", 24'h1, {23'h0, d[14]});
    wr(16'h401D, 24'h0);
    rd(16'h4010);
    chk("err clear", 24'h0, {23'h0, d[14]});
  endtask : t_status
  task automatic t_rdo();
    n0 = n_rdo;
    wr(16'h4018, 24'h0);
    wr(16'h401A, 24'h0);
    repeat (3) @(posedge mclk_i);
    chk("readout", 1, n_rdo - n0);
    wr(16'h4019, 24'h0);
    rd(16'h4010);
    chk("empty", 24'h1, {23'h0, d[11]});
    chk("remaining", 24'h8, {20'h0, d[9:6]});
  endtask : t_rdo

  initial begin
    #(20 * 20000);
    miscompares++;
    wrap_up();
  end
  initial begin
    reset_n_i = 1'b0;
    host = '0;
    trig1 = 1'b0;
    trig2 = 1'b0;
    ev_len = 8'h00;
    chip_id = 8'h00;
    err_bits = 7'h00;
    wait_cyc = 4'h0;
    n_rdo = 0;
    miscompares = 0;
    n_checks = 0;
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i) #1;
    t_reset();
    t_bcast();
    t_read_seq();
    t_write_seq();
    t_trig();
    t_status();
    t_rdo();
    wrap_up();
  end
endmodule : front_end_instruction_sequencer_test
